// [tmr16_filter.sv]
// Shared constants of the 16-bit timer, and the four-sample capture noise filter.
// Assumes one clock, core_clk, with a synchronous active-high reset, and an input
// that is already synchronised to core_clk.
package tmr16_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] ADDR_CTRL_A = 4'h0;
   localparam logic [3:0] ADDR_CTRL_B = 4'h1;
   localparam logic [3:0] ADDR_CNT_LO = 4'h2;
   localparam logic [3:0] ADDR_CNT_HI = 4'h3;
   localparam logic [3:0] ADDR_CAP_LO = 4'h4;
   localparam logic [3:0] ADDR_CAP_HI = 4'h5;
   localparam logic [3:0] ADDR_FLAGS = 4'h6;
   localparam logic [3:0] ADDR_MASK = 4'h7;
   localparam logic [3:0] ADDR_CMP_CTRL = 4'h8;
   localparam int unsigned CTRL_B_FILT_BIT = 7;
   localparam int unsigned CTRL_B_EDGE_BIT = 6;
   localparam int unsigned CTRL_B_WGM_HI_BIT = 4;
   localparam int unsigned CTRL_B_WGM_LO_BIT = 3;
   localparam int unsigned CTRL_B_CS_MSB = 2;
   localparam int unsigned FLAG_OVF_BIT = 0;
   localparam int unsigned FLAG_CAP_BIT = 5;
   localparam int unsigned CMP_SEL_BIT = 2;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam int unsigned FILTER_SAMPLES = 4;
   localparam int unsigned PRESC_W = 10;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_PC8 = 4'h1;
   localparam logic [3:0] WGM_PC9 = 4'h2;
   localparam logic [3:0] WGM_PC10 = 4'h3;
   localparam logic [3:0] WGM_FAST8 = 4'h5;
   localparam logic [3:0] WGM_FAST9 = 4'h6;
   localparam logic [3:0] WGM_FAST10 = 4'h7;
   localparam logic [3:0] WGM_PFC_CAP = 4'h8;
   localparam logic [3:0] WGM_PC_CAP = 4'hA;
   localparam logic [3:0] WGM_CTC_CAP = 4'hC;
   localparam logic [3:0] WGM_FAST_CAP = 4'hE;
   typedef enum logic {TMR16_DIR_UP, TMR16_DIR_DOWN} tmr16_dir_t;
endpackage : tmr16_pkg

`timescale 1ns/10ps
module tmr16_filter
   import tmr16_pkg::*;
#(
   parameter int unsigned SAMPLES = tmr16_pkg::FILTER_SAMPLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic sample_in,
   output logic filtered_out
);
   import tmr16_pkg::*;

   typedef struct packed {
      logic [SAMPLES-1:0] hist;
      logic out;
   } tmr16_filt_state_t;

   tmr16_filt_state_t s_r;
   tmr16_filt_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.hist = {s_r.hist[SAMPLES-2:0], sample_in};
      if (!enable) begin
         s_nxt.out = sample_in;
      end else if (&s_r.hist) begin
         s_nxt.out = 1'b1;
      end else if (~|s_r.hist) begin
         s_nxt.out = 1'b0;
      end
   end

   // Runs on core_clk alone, so the prescaler setting never changes its delay
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign filtered_out = s_r.out;
endmodule : tmr16_filter

// [tmr16_counter.sv]
// 16-bit up/down timer counter with input capture, reached over an 8-bit CPU I/O port.
// Assumes single-cycle CPU strobes on core_clk; pins t1, capture and comparator are async.
`timescale 1ns/10ps
module tmr16_counter (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [tmr16_pkg::ADDR_W-1:0] io_addr,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   input wire logic ext_clock_pin,
   input wire logic capture_input_pin,
   input wire logic comparator_result,
   input wire logic capture_irq_ack,
   input wire logic overflow_irq_ack,
   output logic capture_irq,
   output logic overflow_irq,
   output logic counter_at_top,
   output logic counter_at_bottom
);
   import tmr16_pkg::*;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] cap;
      logic [7:0] temp;
      logic [7:0] rdata;
      logic [1:0] wgm_lo;
      logic [7:0] ctrl_b;
      logic ovf_flag;
      logic cap_flag;
      logic ovf_en;
      logic cap_en;
      logic cmp_sel;
      tmr16_dir_t dir;
      logic [PRESC_W-1:0] presc;
      logic [2:0] t1_sync;
      logic [2:0] pin_sync;
      logic [2:0] cmp_sync;
      logic t1_val;
      logic pin_val;
      logic cmp_val;
      logic t1_prev;
      logic filt_prev;
      logic cap_irq;
      logic ovf_irq;
      logic at_top;
      logic at_bottom;
   } tmr16_state_t;

   tmr16_state_t s_r;
   tmr16_state_t s_nxt;
   logic filt_out;

   function automatic logic [15:0] tmr16_top(input logic [3:0] wgm, input logic [15:0] cap);
      case (wgm)
         WGM_PC8, WGM_FAST8: tmr16_top = TOP_8BIT;
         WGM_PC9, WGM_FAST9: tmr16_top = TOP_9BIT;
         WGM_PC10, WGM_FAST10: tmr16_top = TOP_10BIT;
         WGM_PFC_CAP, WGM_PC_CAP, WGM_CTC_CAP, WGM_FAST_CAP: tmr16_top = cap;
         default: tmr16_top = CNT_MAX;
      endcase
   endfunction : tmr16_top

   function automatic logic tmr16_dual(input logic [3:0] wgm);
      tmr16_dual = (wgm == WGM_PC8) || (wgm == WGM_PC9) || (wgm == WGM_PC10) ||
                   (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP);
   endfunction : tmr16_dual

   function automatic logic tmr16_cap_top(input logic [3:0] wgm);
      tmr16_cap_top = (wgm == WGM_PFC_CAP) || (wgm == WGM_PC_CAP) ||
                      (wgm == WGM_CTC_CAP) || (wgm == WGM_FAST_CAP);
   endfunction : tmr16_cap_top

   function automatic logic tmr16_agree(input logic [2:0] sync, input logic held);
      tmr16_agree = (sync[1] == sync[2]) ? sync[2] : held;
   endfunction : tmr16_agree

   // Filter sits before the edge detector; it sees the chosen, synchronised source
   tmr16_filter #(
      .SAMPLES(FILTER_SAMPLES)
   ) u_filter (
      .core_clk(core_clk),
      .rst(rst),
      .enable(s_r.ctrl_b[CTRL_B_FILT_BIT]),
      .sample_in(s_r.cmp_sel ? s_r.cmp_val : s_r.pin_val),
      .filtered_out(filt_out)
   );

   always_comb begin
      logic [3:0] wgm;
      logic [15:0] top;
      logic tick;
      logic cnt_wr;
      logic cap_evt;
      logic ovf_evt;
      logic edge_hit;
      s_nxt = s_r;
      wgm = {s_r.ctrl_b[CTRL_B_WGM_HI_BIT:CTRL_B_WGM_LO_BIT], s_r.wgm_lo};
      top = tmr16_top(wgm, s_r.cap);
      tick = 1'b0;
      cnt_wr = 1'b0;
      cap_evt = 1'b0;
      ovf_evt = 1'b0;
      edge_hit = 1'b0;

      // Three-stage synchronisers; a level counts once stages two and three agree
      s_nxt.t1_sync = {s_r.t1_sync[1:0], ext_clock_pin};
      s_nxt.pin_sync = {s_r.pin_sync[1:0], capture_input_pin};
      s_nxt.cmp_sync = {s_r.cmp_sync[1:0], comparator_result};
      s_nxt.t1_val = tmr16_agree(s_r.t1_sync, s_r.t1_val);
      s_nxt.pin_val = tmr16_agree(s_r.pin_sync, s_r.pin_val);
      s_nxt.cmp_val = tmr16_agree(s_r.cmp_sync, s_r.cmp_val);
      s_nxt.t1_prev = s_r.t1_val;
      s_nxt.presc = s_r.presc + 1'b1;

      case (s_r.ctrl_b[CTRL_B_CS_MSB:0])
         CS_STOP: tick = 1'b0;
         CS_DIV1: tick = 1'b1;
         CS_DIV8: tick = &s_r.presc[2:0];
         CS_DIV64: tick = &s_r.presc[5:0];
         CS_DIV256: tick = &s_r.presc[7:0];
         CS_DIV1024: tick = &s_r.presc;
         CS_EXT_FALL: tick = s_r.t1_prev && !s_r.t1_val;
         CS_EXT_RISE: tick = !s_r.t1_prev && s_r.t1_val;
         default: tick = 1'b0;
      endcase

      // Edge detector, idle while the capture register defines top
      s_nxt.filt_prev = filt_out;
      if (!tmr16_cap_top(wgm)) begin
         if (s_r.ctrl_b[CTRL_B_EDGE_BIT]) begin
            edge_hit = filt_out && !s_r.filt_prev;
         end else begin
            edge_hit = !filt_out && s_r.filt_prev;
         end
      end
      if (edge_hit) begin
         s_nxt.cap = s_r.cnt;
         cap_evt = 1'b1;
      end

      // CPU port; read data is registered so it appears one cycle after io_re
      s_nxt.rdata = BYTE_RST;
      if (io_re) begin
         case (io_addr)
            ADDR_CTRL_A: s_nxt.rdata = {6'h00, s_r.wgm_lo};
            ADDR_CTRL_B: s_nxt.rdata = s_r.ctrl_b;
            ADDR_CNT_LO: begin
               s_nxt.rdata = s_r.cnt[7:0];
               s_nxt.temp = s_r.cnt[15:8];
            end
            ADDR_CAP_LO: begin
               s_nxt.rdata = s_r.cap[7:0];
               s_nxt.temp = s_r.cap[15:8];
            end
            ADDR_CNT_HI, ADDR_CAP_HI: s_nxt.rdata = s_r.temp;
            ADDR_FLAGS: begin
               s_nxt.rdata[FLAG_OVF_BIT] = s_r.ovf_flag;
               s_nxt.rdata[FLAG_CAP_BIT] = s_r.cap_flag;
            end
            ADDR_MASK: begin
               s_nxt.rdata[FLAG_OVF_BIT] = s_r.ovf_en;
               s_nxt.rdata[FLAG_CAP_BIT] = s_r.cap_en;
            end
            ADDR_CMP_CTRL: s_nxt.rdata[CMP_SEL_BIT] = s_r.cmp_sel;
            default: s_nxt.rdata = BYTE_RST;
         endcase
      end

      if (io_we) begin
         case (io_addr)
            ADDR_CTRL_A: s_nxt.wgm_lo = io_wdata[1:0];
            ADDR_CTRL_B: s_nxt.ctrl_b = {io_wdata[7:6], 1'b0, io_wdata[4:0]};
            ADDR_CNT_HI, ADDR_CAP_HI: s_nxt.temp = io_wdata;
            ADDR_CNT_LO: begin
               s_nxt.cnt = {s_r.temp, io_wdata};
               cnt_wr = 1'b1;
            end
            ADDR_CAP_LO: begin
               // Ignored unless the capture register sets the top
               if (tmr16_cap_top(wgm)) begin
                  s_nxt.cap = {s_r.temp, io_wdata};
               end
            end
            ADDR_MASK: begin
               s_nxt.ovf_en = io_wdata[FLAG_OVF_BIT];
               s_nxt.cap_en = io_wdata[FLAG_CAP_BIT];
            end
            ADDR_CMP_CTRL: s_nxt.cmp_sel = io_wdata[CMP_SEL_BIT];
            default: s_nxt.cmp_sel = s_r.cmp_sel;
         endcase
      end

      // Counting sequence; a CPU write to the counter low byte in the same cycle drops the tick
      if (tick && !cnt_wr) begin
         if (tmr16_dual(wgm)) begin
            if (s_r.dir == TMR16_DIR_UP) begin
               if (s_r.cnt >= top) begin
                  s_nxt.dir = TMR16_DIR_DOWN;
                  s_nxt.cnt = s_r.cnt - 1'b1;
               end else begin
                  s_nxt.cnt = s_r.cnt + 1'b1;
               end
            end else if (s_r.cnt == CNT_BOTTOM) begin
               s_nxt.dir = TMR16_DIR_UP;
               s_nxt.cnt = s_r.cnt + 1'b1;
               ovf_evt = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 1'b1;
            end
         end else begin
            s_nxt.dir = TMR16_DIR_UP;
            if (s_r.cnt == top) begin
               s_nxt.cnt = CNT_BOTTOM;
            end else begin
               s_nxt.cnt = s_r.cnt + 1'b1;
            end
            // CTC flags at MAX; the other single-slope modes flag at top
            if (wgm == WGM_CTC_CAP) begin
               ovf_evt = (s_r.cnt == CNT_MAX);
            end else begin
               ovf_evt = (s_r.cnt == top);
            end
         end
      end

      // Flags: a clear and a set in one cycle leave the flag set
      if (io_we && (io_addr == ADDR_FLAGS) && io_wdata[FLAG_CAP_BIT]) begin
         s_nxt.cap_flag = 1'b0;
      end
      if (io_we && (io_addr == ADDR_FLAGS) && io_wdata[FLAG_OVF_BIT]) begin
         s_nxt.ovf_flag = 1'b0;
      end
      if (capture_irq_ack) begin
         s_nxt.cap_flag = 1'b0;
      end
      if (overflow_irq_ack) begin
         s_nxt.ovf_flag = 1'b0;
      end
      if (cap_evt) begin
         s_nxt.cap_flag = 1'b1;
      end
      if (ovf_evt) begin
         s_nxt.ovf_flag = 1'b1;
      end

      s_nxt.cap_irq = s_nxt.cap_flag && s_nxt.cap_en;
      s_nxt.ovf_irq = s_nxt.ovf_flag && s_nxt.ovf_en;
      s_nxt.at_top = (s_nxt.cnt == tmr16_top({s_nxt.ctrl_b[CTRL_B_WGM_HI_BIT:CTRL_B_WGM_LO_BIT],
                                              s_nxt.wgm_lo}, s_nxt.cap));
      s_nxt.at_bottom = (s_nxt.cnt == CNT_BOTTOM);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_r <= '0;
         s_r.cnt <= CNT_RST;
         s_r.cap <= CAP_RST;
         s_r.dir <= TMR16_DIR_UP;
         s_r.at_bottom <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign io_rdata = s_r.rdata;
   assign capture_irq = s_r.cap_irq;
   assign overflow_irq = s_r.ovf_irq;
   assign counter_at_top = s_r.at_top;
   assign counter_at_bottom = s_r.at_bottom;
endmodule : tmr16_counter

// [tmr16_counter_assertions.sv]
// Port-level checks of the 16-bit timer with capture.
// Assumes core_clk with synchronous active-high rst; bound to tmr16_counter.
`timescale 1ns/10ps
module tmr16_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [tmr16_pkg::ADDR_W-1:0] io_addr,
   input wire logic io_we,
   input wire logic io_re,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic ext_clock_pin,
   input wire logic capture_input_pin,
   input wire logic comparator_result,
   input wire logic capture_irq_ack,
   input wire logic overflow_irq_ack,
   input wire logic capture_irq,
   input wire logic overflow_irq,
   input wire logic counter_at_top,
   input wire logic counter_at_bottom
);
   import tmr16_pkg::*;
   // Quiet count; sync plus filter latency stays well under 15 cycles
   logic [3:0] quiet_r;
   logic pin_q_r;
   logic cmp_q_r;
   always_ff @(posedge core_clk) begin
      pin_q_r <= capture_input_pin;
      cmp_q_r <= comparator_result;
      if (rst || pin_q_r != capture_input_pin || cmp_q_r != comparator_result) begin
         quiet_r <= 4'h0;
      end else if (quiet_r != 4'hF) begin
         quiet_r <= quiet_r + 4'h1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_reset_state;
      $past(rst) |-> counter_at_bottom && !capture_irq && !overflow_irq && io_rdata == 8'h00;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
   property p_rdata_idle;
      !io_re |=> io_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_unmapped;
      io_re && io_addr > ADDR_CMP_CTRL |=> io_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctrlb_rsvd;
      io_re && io_addr == ADDR_CTRL_B |=> !io_rdata[5];
   endproperty
   a_ctrlb_rsvd: assert property (p_ctrlb_rsvd) else $error("reserved bit reads one");
   property p_cap_cause;
      $rose(capture_irq) |-> quiet_r != 4'hF || $past(io_we) || $past(io_we, 2);
   endproperty
   a_cap_cause: assert property (p_cap_cause) else $error("capture without edge");
   property p_cap_ack;
      capture_irq_ack && quiet_r == 4'hF |-> ##[1:2] !capture_irq;
   endproperty
   a_cap_ack: assert property (p_cap_ack) else $error("ack left capture irq");
   property p_cap_w1c;
      io_we && io_addr == ADDR_FLAGS && io_wdata[FLAG_CAP_BIT] && quiet_r == 4'hF
         |-> ##[1:2] !capture_irq;
   endproperty
   a_cap_w1c: assert property (p_cap_w1c) else $error("write one left capture irq");
   property p_ovf_ack;
      overflow_irq_ack && !counter_at_top && !$past(counter_at_top) && !counter_at_bottom
         |-> ##[1:2] !overflow_irq;
   endproperty
   a_ovf_ack: assert property (p_ovf_ack) else $error("ack left overflow irq");
   c_cap: cover property ($rose(capture_irq));
   c_ovf: cover property ($rose(overflow_irq));
   c_leave_bottom: cover property ($fell(counter_at_bottom));
endmodule : tmr16_chk

bind tmr16_counter tmr16_chk u_chk (.core_clk, .rst, .io_addr, .io_we, .io_re, .io_wdata,
   .io_rdata, .ext_clock_pin, .capture_input_pin, .comparator_result, .capture_irq_ack,
   .overflow_irq_ack, .capture_irq, .overflow_irq, .counter_at_top, .counter_at_bottom);

// [tmr16_cpu_model.sv]
// CPU model driving the timer's 8-bit I/O strobes.
// Assumes each task is entered just after a core_clk rising edge.
`timescale 1ns/10ps
module tmr16_cpu_model (
   input wire logic core_clk,
   output logic [tmr16_pkg::ADDR_W-1:0] io_addr,
   output logic io_we,
   output logic io_re,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   import tmr16_pkg::*;
   initial begin
      io_addr = '0;
      io_we = 1'b0;
      io_re = 1'b0;
      io_wdata = 8'h00;
   end
   // One idle cycle after each access keeps strobes single-driven per step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_we = 1'b1;
      @(posedge core_clk);
      #1;
      io_we = 1'b0;
      @(posedge core_clk);
      #1;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      io_addr = a;
      io_re = 1'b1;
      @(posedge core_clk);
      #1;
      io_re = 1'b0;
      d = io_rdata;
      @(posedge core_clk);
      #1;
   endtask : rd
   // Not interruptible, so a shared upper byte stays valid
   task automatic wr16(input logic [ADDR_W-1:0] a, input logic [15:0] v);
      wr(a + 4'h1, v[15:8]);
      wr(a, v[7:0]);
   endtask : wr16
   task automatic rd16(input logic [ADDR_W-1:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 4'h1, v[15:8]);
   endtask : rd16
endmodule : tmr16_cpu_model

// [test_timer16_counter_and_capture.sv]
// Self-checking bench for the 16-bit timer with capture.
// Assumes tmr16_cpu_model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module test_timer16_counter_and_capture;
   import tmr16_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] io_addr;
   logic io_we;
   logic io_re;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic ext_clock_pin = 1'b0;
   logic capture_input_pin = 1'b0;
   logic comparator_result = 1'b0;
   logic capture_irq_ack = 1'b0;
   logic overflow_irq_ack = 1'b0;
   logic capture_irq;
   logic overflow_irq;
   logic counter_at_top;
   logic counter_at_bottom;
   int failures = 0;
   int n_tests = 0;
   int n0;
   int n1;
   logic [15:0] v;
   logic [7:0] b;
   always #2 core_clk = ~core_clk;
   tmr16_counter dut (.core_clk, .rst, .io_addr, .io_we, .io_re, .io_wdata, .io_rdata,
      .ext_clock_pin, .capture_input_pin, .comparator_result, .capture_irq_ack,
      .overflow_irq_ack, .capture_irq, .overflow_irq, .counter_at_top, .counter_at_bottom);
   tmr16_cpu_model cpu (.core_clk, .io_addr, .io_we, .io_re, .io_wdata, .io_rdata);
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk16
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0000, got}, {15'h0000, exp});
   endtask : chk1
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : idle
   // Bounded wait; the count also gives edge-to-flag latency
   task automatic wait_cap(output int n);
      n = 0;
      while (capture_irq !== 1'b1) begin
         idle(1);
         n++;
         if (n > 40) begin
            failures++;
            conclude();
         end
      end
   endtask : wait_cap
   task automatic cap_flag(input logic exp);
      cpu.rd(ADDR_FLAGS, b);
      chk1(b[FLAG_CAP_BIT], exp);
   endtask : cap_flag
   initial begin
      idle(4);
      rst = 1'b0;
      idle(1);
      cpu.rd16(ADDR_CNT_LO, v);
      chk16(v, CNT_BOTTOM);
      chk1(counter_at_bottom, 1'b1);
      cpu.rd(4'hF, b);
      chk16({8'h00, b}, 16'h0000);
      cpu.wr16(ADDR_CNT_LO, 16'h01FF);
      idle(10);
      cpu.rd16(ADDR_CNT_LO, v);
      chk16(v, 16'h01FF);
      cpu.wr(ADDR_CNT_HI, 8'hAB);
      cpu.wr(ADDR_CNT_LO, 8'h11);
      cpu.wr(ADDR_CNT_LO, 8'h22);
      cpu.rd16(ADDR_CNT_LO, v);
      chk16(v, 16'hAB22);
      cpu.wr16(ADDR_CNT_LO, 16'hFFFE);
      cpu.wr(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
      repeat (3) begin
         ext_clock_pin = 1'b1;
         idle(6);
         ext_clock_pin = 1'b0;
         idle(6);
      end
      cpu.wr(ADDR_CTRL_B, 8'h00);
      cpu.rd16(ADDR_CNT_LO, v);
      chk16(v, 16'h0001);
      cap_flag(1'b0);
      chk1(b[FLAG_OVF_BIT], 1'b1);
      cpu.wr(ADDR_MASK, 8'h21);
      idle(2);
      chk1(overflow_irq, 1'b1);
      overflow_irq_ack = 1'b1;
      idle(1);
      overflow_irq_ack = 1'b0;
      idle(2);
      chk1(overflow_irq, 1'b0);
      cpu.wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
      cpu.wr16(ADDR_CNT_LO, 16'h1000);
      cpu.rd16(ADDR_CNT_LO, v);
      chk16(v, 16'h1001);
      cpu.wr(ADDR_CTRL_B, 8'h00);
      cpu.wr16(ADDR_CNT_LO, 16'h0ABC);
      cpu.wr(ADDR_CTRL_B, 8'h40);
      cpu.rd(ADDR_CTRL_B, b);
      chk16({8'h00, b}, 16'h0040);
      capture_input_pin = 1'b1;
      wait_cap(n0);
      cpu.rd16(ADDR_CAP_LO, v);
      chk16(v, 16'h0ABC);
      cap_flag(1'b1);
      idle(4);
      capture_irq_ack = 1'b1;
      idle(1);
      capture_irq_ack = 1'b0;
      idle(2);
      chk1(capture_irq, 1'b0);
      cpu.wr16(ADDR_CNT_LO, 16'h0DEF);
      cpu.wr(ADDR_CTRL_B, 8'h00);
      capture_input_pin = 1'b0;
      wait_cap(n1);
      cpu.rd16(ADDR_CAP_LO, v);
      chk16(v, 16'h0DEF);
      cpu.wr(ADDR_CTRL_B, 8'h40);
      cpu.wr(ADDR_FLAGS, 8'h20);
      cap_flag(1'b0);
      cpu.wr(ADDR_CMP_CTRL, 8'h04);
      cpu.wr(ADDR_FLAGS, 8'h20);
      cpu.wr16(ADDR_CNT_LO, 16'h0333);
      cpu.wr(ADDR_CTRL_B, 8'h40);
      capture_input_pin = 1'b1;
      idle(12);
      cap_flag(1'b0);
      comparator_result = 1'b1;
      wait_cap(n1);
      cpu.rd16(ADDR_CAP_LO, v);
      chk16(v, 16'h0333);
      cpu.wr(ADDR_CMP_CTRL, 8'h00);
      idle(4);
      cpu.wr(ADDR_FLAGS, 8'h20);
      cpu.wr16(ADDR_CNT_LO, 16'h0444);
      cpu.wr(ADDR_CTRL_B, 8'h80);
      capture_input_pin = 1'b0;
      idle(2);
      capture_input_pin = 1'b1;
      idle(15);
      cap_flag(1'b0);
      capture_input_pin = 1'b0;
      wait_cap(n1);
      chk16(16'(n1 - n0), 16'h0004);
      cpu.rd16(ADDR_CAP_LO, v);
      chk16(v, 16'h0444);
      cpu.wr(ADDR_FLAGS, 8'h20);
      cpu.wr16(ADDR_CAP_LO, 16'h0123);
      cpu.rd16(ADDR_CAP_LO, v);
      chk16(v, 16'h0444);
      cpu.wr(ADDR_CTRL_B, 8'h58);
      cpu.wr16(ADDR_CAP_LO, 16'h0123);
      cpu.rd16(ADDR_CAP_LO, v);
      chk16(v, 16'h0123);
      cpu.wr16(ADDR_CNT_LO, 16'h0123);
      chk1(counter_at_top, 1'b1);
      chk1(counter_at_bottom, 1'b0);
      capture_input_pin = 1'b1;
      idle(15);
      cap_flag(1'b0);
      conclude();
   end
endmodule : test_timer16_counter_and_capture
